// ===== pst_defines.svh
// timing constants, field layout and register map of the sample timing block
`ifndef PST_DEFINES_SVH
`define PST_DEFINES_SVH
`define PST_CLK_PS 8000
`define PST_COUNT_NS 100
`define PST_COUNT_CYC ((`PST_COUNT_NS * 1000) / `PST_CLK_PS)
`define PST_FINE_STEP_PS 500
`define PST_RELOAD_US 5
`define PST_RELOAD_CYC ((`PST_RELOAD_US * 1000000) / `PST_CLK_PS)
`define PST_SAMPLE_RESET_A_US 1
`define PST_SAMPLE_RESET_A_CYC ((`PST_SAMPLE_RESET_A_US * 1000000) / `PST_CLK_PS)
`define PST_HOLD_US 1
`define PST_HOLD_CYC ((`PST_HOLD_US * 1000000) / `PST_CLK_PS)
`define PST_SAMPLE_US 51
`define PST_SAMPLE_COUNTS ((`PST_SAMPLE_US * 1000) / `PST_COUNT_NS)
`define PST_CW_INTERVAL_US 70
`define PST_CW_LEAD (((`PST_CW_INTERVAL_US - `PST_SAMPLE_US - `PST_RELOAD_US) * 1000) / `PST_COUNT_NS)
`define PST_COARSE_ONES 20'hFFFFF
`define PST_FRAME_BITS 48
`define PST_PIN_IDLE 4'hC
`define PST_MODE_INT 3
`define PST_MODE_EXT 2
`define PST_MODE_CW 1
`define PST_MODE_GAIN 0
`define PST_REG_STATUS 12'h000
`define PST_REG_CONFIG 12'h004
`define PST_REG_COARSE 12'h008
`define PST_REG_CTRL 12'h00C
`define PST_CTRL_ENABLE 0
`define PST_CTRL_REARM 1
`define PST_CTRL_RESET 1'h1
`endif

// ===== pst_pkg.sv
// types shared by the sample timing block
package pst_pkg;
    // acquisition cycle phases
    typedef enum logic [2:0] {PST_IDLE, PST_FINE, PST_COUNT, PST_RELOAD, PST_SAMPLE_RESET_A} pst_state_e;
endpackage

// ===== pst_timing.sv
// trigger-to-sample timing logic with serial config loader and apb status port
// Notes on behaviour
// R1 - continuous mode free-runs, never resets, ~70us
// R2 - host request sets ready, arming trigger
// R3 - ready plus trigger edge latches trigger
// R4 - fine delay in half nanosecond steps; code rounds down to whole 8 ns clock cycles
// R5 - gated count clock, full first period
// R6 - count clock increments coarse counter to carry
// R7 - carry held one count latches sample
// R8 - sample ends after 51us count decode
// R9 - reload 5us, then 1us reset of flops
// R10 - load strobe low before clock stops
// R11 - sample drives track hold and acquire
// R12 - reset clears ready, sample, trigger except continuous
// R13 - data low pulse rearms, device holds line
// R14 - no data line handshake in continuous mode
// R15 - host changes data only while clock low
// R16 - 48-bit frame order after stop condition
// R17 - coarse all ones means zero delay
// R18 - trigger level converter gets 12-bit code
// R19 - serial clock activity resets loop, reloads counter
// R20 - fields applied after all 48 bits
// R21 - fine steps from delay, ignored continuous mode
`include "pst_defines.svh"
module pst_timing
    import pst_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic serial_clock_in,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_oe,
    input wire logic trigger_int_in,
    input wire logic trigger_ext_in,
    output logic coarse_count_clock,
    output logic counter_reload_strobe_n,
    output logic counter_terminal_carry,
    output logic pre_reset_phase,
    output logic sample_reset_a,
    output logic track_hold,
    output logic sample_acquire,
    output logic [11:0] trigger_level,
    output logic trigger_gain_select,
    output logic continuous_wave_mode
);
    // fine setting to whole clock cycles, rounded down
    function automatic logic [3:0] fine_cycles(input logic [7:0] steps);
        int unsigned ps;
        ps = 32'(steps) * `PST_FINE_STEP_PS;
        return 4'(ps / `PST_CLK_PS);
    endfunction

    // word aligned and mapped
    function automatic logic addr_ok(input logic [11:0] a);
        return a == `PST_REG_STATUS || a == `PST_REG_CONFIG ||
               a == `PST_REG_COARSE || a == `PST_REG_CTRL;
    endfunction

    logic [3:0] sync_a; // first stage, read only by sync_b
    logic [3:0] sync_b; // synchronised pins
    logic [3:0] pin_prev; // for edge detection
    logic scl, sda, scl_rise, sda_rise, sda_fall, scl_edge;
    logic rx_active; // frame receive window after stop
    logic [5:0] bit_cnt;
    logic [46:0] shift;
    logic [47:0] next_frame;
    logic [11:0] cfg_level;
    logic [7:0] cfg_fine;
    logic [19:0] cfg_coarse;
    logic [3:0] cfg_mode;
    logic [6:0] hold_cnt; // serial clock activity timer
    logic serial_clock_hold;
    logic ready, trig, sample, samp_d1;
    logic trig_sel, trig_rise, rearm, soft_rearm, enable, cw;
    pst_state_e state;
    logic [9:0] phase; // cycles spent in fine, reload or sample_reset_a phase
    logic st_count, st_reload, st_sample_reset_a, last_reload, loader;
    logic gate, tick;
    logic [3:0] tick_cnt;
    logic [19:0] coarse;
    logic acc, wr;

    // two flops on every pin before any logic
    // reset to the idle pin levels (clock and data high, triggers low),
    // so release of reset shows no false edge, start or stop on the link
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= `PST_PIN_IDLE;
            sync_b <= `PST_PIN_IDLE;
            pin_prev <= `PST_PIN_IDLE;
        end else begin
            sync_a <= {serial_clock_in, serial_data_in, trigger_int_in, trigger_ext_in};
            sync_b <= sync_a;
            pin_prev <= sync_b;
        end
    end

    assign scl = sync_b[3];
    assign sda = sync_b[2];
    assign scl_rise = scl & ~pin_prev[3];
    assign scl_edge = scl ^ pin_prev[3];
    assign sda_rise = sda & ~pin_prev[2];
    assign sda_fall = ~sda & pin_prev[2];
    assign cw = cfg_mode[`PST_MODE_CW];
    assign next_frame = {shift, sda};

    // frame receiver: start aborts, stop opens a 48-bit window
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_active <= 1'b0;
            bit_cnt <= 6'h0;
            shift <= 47'h0;
            cfg_level <= 12'h0;
            cfg_fine <= 8'h0;
            cfg_coarse <= 20'h0;
            cfg_mode <= 4'h0;
        end else if (scl && sda_fall) begin
            rx_active <= 1'b0;
        end else if (scl && sda_rise) begin
            // R16 frame follows stop
            rx_active <= 1'b1;
            bit_cnt <= 6'h0;
        end else if (scl_rise && rx_active) begin
            shift <= next_frame[46:0];
            bit_cnt <= bit_cnt + 6'h1;
            // R20 apply when complete
            if (bit_cnt == 6'(`PST_FRAME_BITS - 1)) begin
                rx_active <= 1'b0;
                cfg_level <= next_frame[43:32];
                cfg_fine <= next_frame[31:24];
                cfg_coarse <= next_frame[23:4];
                cfg_mode <= next_frame[3:0];
            end
        end
    end

    // R18 level code out
    assign trigger_level = cfg_level;
    assign trigger_gain_select = cfg_mode[`PST_MODE_GAIN];
    assign continuous_wave_mode = cw;

    // serial activity keeps the loop reset for a while after each edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 7'h0;
        end else if (scl_edge) begin
            hold_cnt <= 7'(`PST_HOLD_CYC);
        end else if (hold_cnt != 7'h0) begin
            hold_cnt <= hold_cnt - 7'h1;
        end
    end
    assign serial_clock_hold = hold_cnt != 7'h0;

    // host rearm: data falls while clock low outside a frame
    // R14 no handshake in continuous mode
    assign rearm = sda_fall & ~scl & ~rx_active & ~cw;

    // ready flop, a request in the clearing cycle wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready <= 1'b0;
        end else if ((rearm || soft_rearm) && !cw) begin
            // R2 request arms
            ready <= 1'b1;
        end else if (st_sample_reset_a) begin
            // R12 stop retrigger
            ready <= 1'b0;
        end
    end

    // R13 hold data low while ready; released with clock high for stop
    assign serial_data_out = 1'b0;
    assign serial_data_oe = ready & ~cw & ~rx_active & ~scl;

    // trigger source per mode bits
    assign trig_sel = cfg_mode[`PST_MODE_INT] ? sync_b[1] :
                      cfg_mode[`PST_MODE_EXT] ? sync_b[0] : 1'b0;
    assign trig_rise = trig_sel & ~(cfg_mode[`PST_MODE_INT] ? pin_prev[1] : pin_prev[0]);

    // trigger latch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig <= 1'b0;
        end else if (ready && trig_rise && !trig) begin
            // R3 latch on edge
            trig <= 1'b1;
        end else if (serial_clock_hold || ((st_reload || st_sample_reset_a) && !cw)) begin
            // R12 reset from pre-reset on
            trig <= 1'b0;
        end
    end

    assign st_count = state == PST_COUNT;
    assign st_reload = state == PST_RELOAD;
    assign st_sample_reset_a = state == PST_SAMPLE_RESET_A;
    assign last_reload = st_reload && phase == 10'(`PST_RELOAD_CYC - 1);
    // R8 sample delayed one count and decoded
    assign loader = st_count & tick & samp_d1 & (coarse == 20'(`PST_SAMPLE_COUNTS));

    // acquisition sequence
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PST_IDLE;
            phase <= 10'h0;
        end else if (serial_clock_hold || !enable) begin
            // R19 serial traffic resets loop
            state <= PST_IDLE;
            phase <= 10'h0;
        end else begin
            unique case (state)
                PST_IDLE: begin
                    // R1 no trigger needed in continuous mode
                    if (cw || trig) begin
                        state <= PST_FINE;
                    end
                end
                PST_FINE: begin
                    // R4 fine delay; R21 ignored in continuous mode
                    if (cw || phase >= 10'(fine_cycles(cfg_fine))) begin
                        state <= PST_COUNT;
                        phase <= 10'h0;
                    end else begin
                        phase <= phase + 10'h1;
                    end
                end
                PST_COUNT: begin
                    if (loader) begin
                        state <= PST_RELOAD;
                    end
                end
                PST_RELOAD: begin
                    // R9 reload for about 5us
                    if (last_reload) begin
                        state <= cw ? PST_FINE : PST_SAMPLE_RESET_A;
                        phase <= 10'h0;
                    end else begin
                        phase <= phase + 10'h1;
                    end
                end
                PST_SAMPLE_RESET_A: begin
                    // R9 flops reset for about 1us
                    if (phase == 10'(`PST_SAMPLE_RESET_A_CYC - 1)) begin
                        state <= PST_IDLE;
                        phase <= 10'h0;
                    end else begin
                        phase <= phase + 10'h1;
                    end
                end
            endcase
        end
    end

    assign pre_reset_phase = st_reload;
    // R1 continuous mode never sees the major reset
    assign sample_reset_a = st_sample_reset_a;

    // R5 gated clock restarts from zero, so its first period is full
    // R10 runs one count into reload, then stops with load still low
    assign gate = st_count | (st_reload & (phase < 10'(`PST_COUNT_CYC))) | serial_clock_hold;
    assign tick = gate & (tick_cnt == 4'(`PST_COUNT_CYC - 1));

    // count clock divider; the last period may be cut short
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 4'h0;
            coarse_count_clock <= 1'b0;
        end else begin
            tick_cnt <= (gate && !tick) ? tick_cnt + 4'h1 : 4'h0;
            coarse_count_clock <= gate && !tick && tick_cnt < 4'(`PST_COUNT_CYC / 2 - 1);
        end
    end

    // R10 strobe low through reload, high again in the same cycle that sample_reset_a starts
    assign counter_reload_strobe_n = ~(st_reload | serial_clock_hold);

    // coarse counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            coarse <= 20'h0;
        end else if (tick) begin
            if (!counter_reload_strobe_n) begin
                // R17 all ones gives carry at once; R1 fixed lead in cw
                coarse <= cw ? `PST_COARSE_ONES - 20'(`PST_CW_LEAD - 1) : cfg_coarse;
            end else begin
                // R6 count up to carry
                coarse <= coarse + 20'h1;
            end
        end
    end
    assign counter_terminal_carry = &coarse;

    // sample flops
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample <= 1'b0;
            samp_d1 <= 1'b0;
        end else begin
            // R7 carry sampled only at count ticks, so short pulses are missed
            if (tick && st_count && counter_terminal_carry && !sample) begin
                sample <= 1'b1;
            end else if (loader || st_sample_reset_a) begin
                // R12 cleared by loader and reset
                sample <= 1'b0;
            end
            if (!sample) begin
                samp_d1 <= 1'b0;
            end else if (tick) begin
                samp_d1 <= 1'b1;
            end
        end
    end

    // R11 hold the tracker and acquire while sampling
    assign track_hold = sample;
    assign sample_acquire = sample;

    // apb slave: zero wait state, errors on unmapped words
    assign acc = psel & penable;
    assign pready = acc;
    assign pslverr = acc & ~addr_ok(paddr);
    assign wr = acc & pwrite & (paddr == `PST_REG_CTRL);

    // control register: enable stays, rearm is a write-one pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= `PST_CTRL_RESET;
            soft_rearm <= 1'b0;
        end else begin
            soft_rearm <= wr & pwdata[`PST_CTRL_REARM];
            if (wr) begin
                enable <= pwdata[`PST_CTRL_ENABLE];
            end
        end
    end

    // read data captured in the setup cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable) begin
            unique case (paddr)
                `PST_REG_STATUS: prdata <= {21'h0, state, 3'h0, cw,
                                            serial_clock_hold, sample, trig, ready};
                `PST_REG_CONFIG: prdata <= {4'h0, cfg_mode, cfg_fine, 4'h0, cfg_level};
                `PST_REG_COARSE: prdata <= {12'h0, cfg_coarse};
                `PST_REG_CTRL: prdata <= {31'h0, enable};
                default: prdata <= 32'h0;
            endcase
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_cw_no_reset;
        cw |-> !sample_reset_a;
    endproperty
    a_cw_no_reset: assert property (p_cw_no_reset) else $error("reset in cw"); // R1

    property p_trig_needs_ready;
        $rose(trig) |-> $past(ready);
    endproperty
    a_trig_needs_ready: assert property (p_trig_needs_ready) else $error("trig w/o ready"); // R3

    property p_fine_len;
        $rose(st_count) && !cw |-> $past(phase) == 10'($past(fine_cycles(cfg_fine)));
    endproperty
    a_fine_len: assert property (p_fine_len) else $error("fine delay wrong"); // R4

    property p_tick_period;
        tick |=> !tick [*8];
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("count clock short"); // R5

    property p_carry_sample;
        tick && st_count && counter_terminal_carry && !sample |=> sample;
    endproperty
    a_carry_sample: assert property (p_carry_sample) else $error("carry missed"); // R7

    property p_loader;
        $rose(st_reload) |-> $past(samp_d1) && $past(coarse) == 20'(`PST_SAMPLE_COUNTS);
    endproperty
    a_loader: assert property (p_loader) else $error("sample width wrong"); // R8

    property p_reload_len;
        $rose(st_sample_reset_a) |-> $past(phase) == 10'(`PST_RELOAD_CYC - 1) && $past(st_reload);
    endproperty
    a_reload_len: assert property (p_reload_len) else $error("reload length wrong"); // R9

    property p_strobe_sample_reset_a;
        $rose(sample_reset_a) |-> counter_reload_strobe_n [*8];
    endproperty
    a_strobe_sample_reset_a: assert property (p_strobe_sample_reset_a) else $error("strobe low in sample_reset_a"); // R10

    property p_sample_reset_a_clears;
        sample_reset_a |=> !sample && !samp_d1;
    endproperty
    a_sample_reset_a_clears: assert property (p_sample_reset_a_clears) else $error("sample not reset"); // R12

    property p_rearm;
        rearm && !serial_clock_hold |=> ready;
    endproperty
    a_rearm: assert property (p_rearm) else $error("rearm lost"); // R13

    property p_cw_no_hold;
        cw |-> !serial_data_oe;
    endproperty
    a_cw_no_hold: assert property (p_cw_no_hold) else $error("cw handshake"); // R14

    c_sample: cover property ($rose(sample));
    c_sample_reset_a: cover property ($fell(sample_reset_a));
    c_cw_sample: cover property (cw && $rose(sample));
    c_cfg: cover property ($fell(rx_active) && !scl);
endmodule

// ===== pst_host_model.sv
// behavioural host meter: serial clock plus open-drain data line
module pst_host_model (
    output logic serial_clock,
    output logic data_wire,
    input wire logic dev_pull_low
);
    timeunit 1ns;
    timeprecision 100ps;
    logic host_rel; // 1 = host lets the pull-up hold the line
    // open-drain wire: released means pulled up, either party pulls low
    assign data_wire = host_rel & ~dev_pull_low;
    // clock idles high between frames, it only moves inside frames and rearm requests
    initial begin
        serial_clock = 1'b1;
        host_rel = 1'b1;
    end
    task automatic put_bit(input logic b);
        begin
            serial_clock = 1'b0;
            #16 host_rel = b;
            #16 serial_clock = 1'b1;
            #32;
        end
    endtask
    task automatic send_frame(input logic [47:0] f, input int nbits);
        begin
            host_rel = 1'b0;
            #16 host_rel = 1'b1;
            #16;
            for (int i = 0; i < nbits; i++) put_bit(f[47 - i]);
            // trailing released bit, ignored by a device that counts to 48
            put_bit(1'b1);
            // start in mid-stream throws a short frame away
            if (nbits < 48) begin
                #16 host_rel = 1'b0;
                #16 put_bit(1'b1);
            end
        end
    endtask
    task automatic rearm(output logic held);
        begin
            serial_clock = 1'b0;
            #16 host_rel = 1'b0;
            #48 host_rel = 1'b1;
            // line still low after release means the device holds it
            #16 held = ~data_wire;
            serial_clock = 1'b1;
            #32;
        end
    endtask
endmodule

// ===== pst_timing_tb.sv
// self-checking bench for the sample timing block
`include "pst_defines.svh"
module pst_timing_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0] paddr, trigger_level;
    logic [31:0] pwdata, prdata, rd, seed;
    logic sclk, swire, sd_out, sd_oe, trig_int, trig_ext, err, held, sample_reset_a_seen;
    logic cclk, load_n, carry, pre_rst, sample_reset_a_rst, t_hold, s_acq, gain, cw;
    logic [3:0] mon; // watched levels: sample, reload, sample_reset_a, count clock
    logic [47:0] frame;
    int err_count, checks_done, n, w;
    assign mon = {cclk, sample_reset_a_rst, pre_rst, t_hold};
    pst_timing dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_clock_in(sclk), .serial_data_in(swire),
        .serial_data_out(sd_out), .serial_data_oe(sd_oe), .trigger_int_in(trig_int),
        .trigger_ext_in(trig_ext), .coarse_count_clock(cclk), .counter_reload_strobe_n(load_n),
        .counter_terminal_carry(carry), .pre_reset_phase(pre_rst), .sample_reset_a(sample_reset_a_rst),
        .track_hold(t_hold), .sample_acquire(s_acq), .trigger_level(trigger_level),
        .trigger_gain_select(gain), .continuous_wave_mode(cw));
    pst_host_model host (.serial_clock(sclk), .data_wire(swire), .dev_pull_low(sd_oe));
    // free-running bus clock, 8 ns
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // sticky flag: any major reset seen since last cleared
    always @(posedge pclk) if (sample_reset_a_rst === 1'b1) sample_reset_a_seen <= 1'b1;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic give_verdict;
        if (err_count == 0 && checks_done > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // bounded wait for a watched level; k counts the edges spent
    task automatic wait_mon(input int b, input logic v, input int lim, output int k);
        k = 0;
        while (mon[b] !== v && k < lim) begin
            @(posedge pclk);
            k++;
        end
        if (mon[b] !== v) begin
            chk(mon, {28'h0, v} << b);
            give_verdict();
        end
    endtask
    // one apb transfer; the answer is taken at the edge that sees pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
            output logic [31:0] r, output logic e);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            chk(pready, 1'h1);
            give_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic pulse_trig(input logic use_int);
        @(posedge pclk);
        trig_int <= use_int;
        trig_ext <= ~use_int;
        repeat (4) @(posedge pclk);
        trig_int <= 1'b0;
        trig_ext <= 1'b0;
    endtask
    // full triggered cycle: rearm, trigger, sample, reload, sample_reset_a
    task automatic acquire(input logic use_int);
        int sw;
        sw = `PST_SAMPLE_COUNTS * `PST_COUNT_CYC;
        host.rearm(held);
        chk(held, 1'h1);
        // the rearm clock edges hold the loop idle for a while
        repeat (140) @(posedge pclk);
        apb(1'b0, `PST_REG_STATUS, 32'h0, rd, err);
        chk(rd[0], 1'h1);
        pulse_trig(use_int);
        apb(1'b0, `PST_REG_STATUS, 32'h0, rd, err);
        chk(rd[1], 1'h1);
        chk(carry, 1'h1);
        wait_mon(0, 1'b1, 400, n);
        chk({t_hold, s_acq}, 2'h3);
        chk({carry, sd_out}, 2'h0);
        wait_mon(0, 1'b0, 7000, w);
        chk((w - sw) <= 36 && (sw - w) <= 36, 1'h1);
        wait_mon(1, 1'b1, 30, n);
        repeat (3) @(posedge pclk);
        chk(load_n, 1'h0);
        wait_mon(1, 1'b0, 700, w);
        chk((w + 3 - `PST_RELOAD_CYC) <= 4 && (`PST_RELOAD_CYC - w - 3) <= 4, 1'h1);
        wait_mon(2, 1'b1, 10, n);
        chk(load_n, 1'h1);
        wait_mon(2, 1'b0, 200, w);
        chk((w - `PST_SAMPLE_RESET_A_CYC) <= 3 && (`PST_SAMPLE_RESET_A_CYC - w) <= 3, 1'h1);
        apb(1'b0, `PST_REG_STATUS, 32'h0, rd, err);
        chk(rd[2:0], 3'h0);
        // no rearm, so a fresh trigger must not start a sample
        pulse_trig(use_int);
        repeat (300) @(posedge pclk);
        chk(t_hold, 1'h0);
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h0;
        pwdata = 32'h0;
        trig_int = 1'b0;
        trig_ext = 1'b0;
        sample_reset_a_seen = 1'b0;
        err_count = 0;
        checks_done = 0;
        seed = 32'h3BEF269F;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        // reset contents of the map, last address unmapped
        for (int i = 0; i < 5; i++) begin
            apb(1'b0, 12'(i * 4), 32'h0, rd, err);
            chk(rd, {31'h0, i == 3});
            chk(err, i == 4);
        end
        // random setups: external mode, then internal mode
        for (int i = 0; i < 2; i++) begin
            seed = xs(seed);
            frame = {4'h0, seed[11:0], seed[19:12], `PST_COARSE_ONES, i[0], ~i[0], 1'b0, seed[31]};
            host.send_frame(frame, 48);
            repeat (140) @(posedge pclk);
            chk(trigger_level, frame[43:32]);
            chk({cw, gain}, {1'b0, frame[0]});
            apb(1'b0, `PST_REG_CONFIG, 32'h0, rd, err);
            chk(rd, {4'h0, frame[3:0], frame[31:24], 4'h0, frame[43:32]});
            apb(1'b0, `PST_REG_COARSE, 32'h0, rd, err);
            chk(rd, {12'h0, frame[23:4]});
            acquire(i[0]);
        end
        // a cut-short frame leaves the applied setup alone
        host.send_frame(~frame, 20);
        repeat (140) @(posedge pclk);
        chk(trigger_level, frame[43:32]);
        host.send_frame({4'h0, 12'h5A5, 8'h10, 20'h0, 4'h2}, 48);
        host.rearm(held);
        chk(held, 1'h0);
        chk(cw, 1'h1);
        sample_reset_a_seen = 1'b0;
        wait_mon(0, 1'b1, 12000, n);
        wait_mon(3, 1'b1, 20, n);
        wait_mon(3, 1'b0, 20, n);
        wait_mon(3, 1'b1, 20, w);
        chk(n + w, `PST_COUNT_CYC);
        wait_mon(0, 1'b0, 7000, n);
        wait_mon(0, 1'b1, 12000, w);
        chk((n + w) > 7800 && (n + w) < 9700, 1'h1);
        chk(sample_reset_a_seen, 1'h0);
        give_verdict();
    end
endmodule
